// ### csi_slave_rx.sv
/*
  Slave receive channel of a three-wire clocked serial port. The master
  drives the serial clock; frames shift in, pass a 16-word FIFO and land in
  a data register read by software. A transmit-side buffer keeps the
  overwrite-on-full behaviour for continuous transmission.
  Assumes pins are asynchronous to MCLK and the serial clock period is at
  least six MCLK periods.
*/
module csi_slave_rx #(
  parameter int FIFO_W = csi_slave_pkg::DATA_W,
  parameter int FIFO_D = csi_slave_pkg::FIFO_DEPTH
)
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic ENABLE,
  input wire logic SERIAL_CLOCK_INPUT,
  input wire logic SERIAL_DATA_INPUT,
  input wire logic DATA_PHASE_SELECT,
  input wire logic CLOCK_PHASE_SELECT,
  input wire logic LEN_EIGHT,
  input wire logic LSB_FIRST,
  input wire logic INTERRUPT_SOURCE_SELECT,
  input wire logic DATA_READ,
  output logic [7:0] SERIAL_DATA_REGISTER,
  output logic DATA_VALID,
  input wire logic OVERRUN_CLEAR,
  output logic OVERRUN_FLAG,
  output logic TRANSFER_END_INTERRUPT,
  output logic FIFO_READY,
  input wire logic TX_WRITE,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_TAKE,
  output logic [7:0] TX_BUFFER,
  output logic BUFFER_FULL_FLAG
);
  logic [1:0] sck_sync_q;
  logic [1:0] si_sync_q;
  logic sck_prev_q;
  logic [1:0] warm_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic frame_done;
  logic [7:0] frame_data;
  logic sck_now;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_in_ready;
  logic load;
  logic [3:0] frame_len;

  // Pins pass two flip-flops before any logic looks at them.
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sck_sync_q <= 2'h0;
      si_sync_q <= 2'h0;
    end
    else if (CE)
    begin
      sck_sync_q <= {sck_sync_q[0], SERIAL_CLOCK_INPUT};
      si_sync_q <= {si_sync_q[0], SERIAL_DATA_INPUT};
    end
  end

  // Polarity follows the phase select; the clock is never generated here.
  assign sck_now = sck_sync_q[1] ^ CLOCK_PHASE_SELECT;

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sck_prev_q <= 1'b0;
      warm_q <= 2'h0;
    end
    else if (CE)
    begin
      sck_prev_q <= sck_now;
      if (warm_q != 2'h3)
      begin
        warm_q <= warm_q + 2'h1;
      end
    end
  end

  // Idle level is high in forward sense, so the first activity is a fall.
  // Edges count only once the synchroniser and the previous level hold real
  // pin levels, so the release of reset never looks like clock activity.
  assign lead_edge = (warm_q == 2'h3) && sck_prev_q && !sck_now;
  assign trail_edge = (warm_q == 2'h3) && !sck_prev_q && sck_now;
  // Phase 1 presents data half a clock earlier, so it is taken on the
  // leading edge; phase 0 takes it on the trailing edge.
  assign sample_edge = DATA_PHASE_SELECT ? lead_edge : trail_edge;

  assign frame_len = LEN_EIGHT ? 4'(csi_slave_pkg::LONG_LEN)
                               : 4'(csi_slave_pkg::SHORT_LEN);
  assign frame_done = ENABLE && sample_edge && (cnt_q == frame_len - 4'h1);

  // Bits enter at the top for LSB first and at the bottom for MSB first.
  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic b,
                                          input logic lsb,
                                          input logic eight);
    logic [7:0] r;
    r = lsb ? {b, s[7:1]} : {s[6:0], b};
    // Seven-bit words keep bit 7 clear so no stale bit leaks in.
    if (!eight)
    begin
      r = lsb ? {1'b0, b, s[6:1]} : {1'b0, s[5:0], b};
    end
    return r;
  endfunction

  assign frame_data = shift_in(shift_q, si_sync_q[1], LSB_FIRST, LEN_EIGHT);

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      shift_q <= csi_slave_pkg::DATA_RESET;
      cnt_q <= csi_slave_pkg::CNT_RESET;
    end
    else if (CE)
    begin
      if (!ENABLE)
      begin
        shift_q <= csi_slave_pkg::DATA_RESET;
        cnt_q <= csi_slave_pkg::CNT_RESET;
      end
      else if (sample_edge)
      begin
        shift_q <= frame_data;
        cnt_q <= frame_done ? csi_slave_pkg::CNT_RESET : cnt_q + 4'h1;
      end
    end
  end

  // A frame that finds the FIFO full is dropped and counted as an overrun.
  csi_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk(MCLK),
    .rst_b(RST_B),
    .ce(CE),
    .in_valid(frame_done),
    .in_ready(fifo_in_ready),
    .in_data(frame_data),
    .out_valid(fifo_out_valid),
    .out_ready(load),
    .out_data(fifo_out_data),
    .level()
  );
  assign FIFO_READY = fifo_in_ready;

  // The data register is refilled only once software has read it.
  assign load = fifo_out_valid && (!DATA_VALID || DATA_READ);

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      SERIAL_DATA_REGISTER <= csi_slave_pkg::DATA_RESET;
      DATA_VALID <= 1'b0;
    end
    else if (CE)
    begin
      if (load)
      begin
        SERIAL_DATA_REGISTER <= fifo_out_data;
        DATA_VALID <= 1'b1;
      end
      else if (DATA_READ)
      begin
        DATA_VALID <= 1'b0;
      end
    end
  end

  // Overrun is the only error; a set in the clear cycle wins.
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      OVERRUN_FLAG <= 1'b0;
    end
    else if (CE)
    begin
      if (frame_done && !fifo_in_ready)
      begin
        OVERRUN_FLAG <= 1'b1;
      end
      else if (OVERRUN_CLEAR)
      begin
        OVERRUN_FLAG <= 1'b0;
      end
    end
  end

  // Only the transfer-end source is meaningful here; the select input is
  // expected at 0 and a 1 suppresses the pulse rather than faking an empty.
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      TRANSFER_END_INTERRUPT <= 1'b0;
    end
    else if (CE)
    begin
      TRANSFER_END_INTERRUPT <= frame_done && !INTERRUPT_SOURCE_SELECT;
    end
  end

  // Transmit buffer: a write while full simply replaces the pending word.
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      TX_BUFFER <= csi_slave_pkg::DATA_RESET;
      BUFFER_FULL_FLAG <= 1'b0;
    end
    else if (CE)
    begin
      if (TX_WRITE)
      begin
        TX_BUFFER <= TX_DATA;
        BUFFER_FULL_FLAG <= 1'b1;
      end
      else if (TX_TAKE)
      begin
        BUFFER_FULL_FLAG <= 1'b0;
      end
    end
  end
endmodule

// ### csi_slave_pkg.sv
/*
  Package for the clocked serial slave receive channel: data width, FIFO depth,
  reset values, frame lengths and timing counts.
  Assumes a single operation clock at the rate given by MCLK_HZ.
*/
// Notes on behaviour
// - The receiver shifts data only on edges of the master-supplied serial clock.
// - Overrun is the only error the receive channel detects and flags.
// - The serial clock is sampled by the operation clock; max rate is fmck/6.
// - Phase 0 samples on the trailing edge; phase 1 half a period earlier, on first clock activity.
// - Clock phase 0 uses the serial clock as is; 1 uses it inverted.
// - A transmit write while the buffer is full replaces the pending data.
package csi_slave_pkg;
  localparam int DATA_W = 8;
  localparam int SHORT_LEN = 7;
  localparam int LONG_LEN = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int MCLK_HZ = 10_000_000;
  localparam int MIN_SCK_PERIOD_CYC = 6;
  localparam int ENABLE_SETTLE_CYC = 4;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int SYNC_STAGES = 2;
endpackage

// ### csi_fifo.sv
/*
  Synchronous FIFO of flip-flops with valid and ready on both sides.
  Assumes one clock, an active-low asynchronous reset and a clock enable.
*/
module csi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;
  assign out_data = mem_q[rd_q];
  assign level = cnt_q;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ### csi_master_model.sv
/*
  Serial master model: sends one frame at a time on clock and data.
  Assumes the bench changes inv only while the channel is disabled.
*/
module csi_master_model (
  input wire logic clk,
  input wire logic inv,
  output logic sck,
  output logic sd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic raw = 1'b1;
  initial sd = 1'b0;
  assign sck = raw ^ inv;
  function automatic logic pick(input logic [7:0] w, input int k,
                                input int n, input logic lsb);
    return lsb ? w[k] : w[n-1-k];
  endfunction
  // Clock stands still between frames; data flips so stale bits never match.
  // Data moves between the two edges, so a slave sampling on the wrong edge
  // of the selected phase picks up a neighbouring bit.
  task automatic send(input logic [7:0] w, input int n, input logic lsb,
                      input logic ph);
    @(posedge clk) if (ph) sd <= pick(w, 0, n, lsb);
    repeat (2) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk) raw <= 1'b0;
      @(posedge clk) if (!ph) sd <= pick(w, i, n, lsb);
      repeat (2) @(posedge clk);
      raw <= 1'b1;
      if (ph && i < n - 1)
        sd <= pick(w, i + 1, n, lsb);
      repeat (3) @(posedge clk);
    end
    @(posedge clk) sd <= ~sd;
  endtask
endmodule

// ### csi_slave_rx_asserts.sv
/*
  Checker for csi_slave_rx, bound below.
  Assumes CE is held high.
*/
module csi_slave_rx_asserts (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic DATA_READ,
  input wire logic [7:0] SERIAL_DATA_REGISTER,
  input wire logic DATA_VALID,
  input wire logic OVERRUN_CLEAR,
  input wire logic OVERRUN_FLAG,
  input wire logic TRANSFER_END_INTERRUPT,
  input wire logic FIFO_READY,
  input wire logic INTERRUPT_SOURCE_SELECT,
  input wire logic TX_WRITE,
  input wire logic [7:0] TX_DATA,
  input wire logic [7:0] TX_BUFFER,
  input wire logic BUFFER_FULL_FLAG
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);
  // A frame spans at least seven serial periods, so pulses stay far apart.
  sequence s_quiet;
    !TRANSFER_END_INTERRUPT [*8];
  endsequence
  sequence s_kept;
    DATA_VALID ##0 $stable(SERIAL_DATA_REGISTER);
  endsequence
  a_irq_spacing: assert property (
    TRANSFER_END_INTERRUPT |=> s_quiet) else $error("irq spacing");
  a_load_after_end: assert property (
    TRANSFER_END_INTERRUPT && !DATA_VALID |=> DATA_VALID) else $error("load");
  a_unread_kept: assert property (
    DATA_VALID && !DATA_READ |=> s_kept) else $error("data lost");
  a_read_pops: assert property (
    DATA_READ && !FIFO_READY |=> DATA_VALID) else $error("pop");
  a_empty_ready: assert property (
    !DATA_VALID |-> FIFO_READY) else $error("empty");
  a_ovf_sticky: assert property (
    OVERRUN_FLAG && !OVERRUN_CLEAR |=> OVERRUN_FLAG) else $error("sticky");
  a_ovf_clear: assert property (
    OVERRUN_CLEAR && FIFO_READY |=> !OVERRUN_FLAG) else $error("clear");
  a_ovf_cause: assert property (
    $rose(OVERRUN_FLAG) |-> !$past(FIFO_READY)) else $error("cause");
  a_isel_masks: assert property (
    INTERRUPT_SOURCE_SELECT |=> !TRANSFER_END_INTERRUPT)
    else $error("masked");
  a_tx_overwrite: assert property (
    TX_WRITE |=> BUFFER_FULL_FLAG && TX_BUFFER == $past(TX_DATA))
    else $error("overwrite");
endmodule
bind csi_slave_rx csi_slave_rx_asserts chk (.MCLK(MCLK), .RST_B(RST_B),
  .DATA_READ(DATA_READ), .SERIAL_DATA_REGISTER(SERIAL_DATA_REGISTER),
  .DATA_VALID(DATA_VALID), .OVERRUN_CLEAR(OVERRUN_CLEAR),
  .OVERRUN_FLAG(OVERRUN_FLAG), .FIFO_READY(FIFO_READY),
  .TRANSFER_END_INTERRUPT(TRANSFER_END_INTERRUPT),
  .INTERRUPT_SOURCE_SELECT(INTERRUPT_SOURCE_SELECT),
  .TX_WRITE(TX_WRITE), .TX_DATA(TX_DATA), .TX_BUFFER(TX_BUFFER),
  .BUFFER_FULL_FLAG(BUFFER_FULL_FLAG));

// ### clocked_serial_slave_channel_test.sv
/*
  Self-checking bench for csi_slave_rx with a serial master model.
  Assumes the checker binds itself.
*/
module clocked_serial_slave_channel_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic en = 1'b0;
  logic rd = 1'b0;
  logic oclr = 1'b0;
  logic txw = 1'b0;
  logic txt = 1'b0;
  logic isel = 1'b0;
  logic irq;
  int irqs = 0;
  logic [3:0] c = 4'h8;
  logic [7:0] txd = 8'h00;
  logic sck, sd, val, ovf, rdy, bff;
  logic [7:0] sdr, txb;
  int fails = 0;
  int compares = 0;
  csi_master_model m (.clk(mclk), .inv(c[0]), .sck(sck), .sd(sd));
  csi_slave_rx dut (.MCLK(mclk), .RST_B(rst_b), .CE(1'b1), .ENABLE(en),
    .SERIAL_CLOCK_INPUT(sck), .SERIAL_DATA_INPUT(sd),
    .DATA_PHASE_SELECT(c[1]), .CLOCK_PHASE_SELECT(c[0]),
    .LEN_EIGHT(c[3]), .LSB_FIRST(c[2]), .INTERRUPT_SOURCE_SELECT(isel),
    .DATA_READ(rd), .SERIAL_DATA_REGISTER(sdr), .DATA_VALID(val),
    .OVERRUN_CLEAR(oclr), .OVERRUN_FLAG(ovf), .TRANSFER_END_INTERRUPT(irq),
    .FIFO_READY(rdy), .TX_WRITE(txw), .TX_DATA(txd), .TX_TAKE(txt),
    .TX_BUFFER(txb), .BUFFER_FULL_FLAG(bff));
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  // Each one-cycle interrupt pulse is counted once.
  always @(posedge mclk)
  begin
    if (irq === 1'b1)
      irqs <= irqs + 1;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cfg(input logic [3:0] v);
    @(posedge mclk) en <= 1'b0;
    @(posedge mclk) c <= v;
    repeat (5) @(posedge mclk);
    en <= 1'b1;
  endtask
  task automatic get(input logic [7:0] e);
    @(negedge mclk);
    for (int k = 0; k < 300 && val !== 1'b1; k++)
      @(negedge mclk);
    chk({7'h0, val}, 8'h01);
    chk(sdr, e);
    @(posedge mclk) rd <= 1'b1;
    @(posedge mclk) rd <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic t_formats;
    logic [3:0] f [5] = '{4'h8, 4'he, 4'h5, 4'h3, 4'hf};
    logic [7:0] w [5] = '{8'ha5, 8'h3c, 8'hd3, 8'h96, 8'h4e};
    for (int i = 0; i < 5; i++)
    begin
      cfg(f[i]);
      m.send(w[i], f[i][3] ? 8 : 7, f[i][2], f[i][1]);
      get(f[i][3] ? w[i] : {1'b0, w[i][6:0]});
      chk(8'(irqs), 8'(i + 1));
    end
  endtask
  task automatic t_isel;
    int base;
    cfg(4'h8);
    base = irqs;
    fork
      m.send(8'h69, 8, 1'b0, 1'b0);
      begin
        repeat (20) @(posedge mclk);
        isel <= 1'b1;
      end
    join
    get(8'h69);
    chk(8'(irqs - base), 8'h00);
    @(posedge mclk) isel <= 1'b0;
    m.send(8'h96, 8, 1'b0, 1'b0);
    get(8'h96);
    chk(8'(irqs - base), 8'h01);
  endtask
  task automatic t_overrun;
    cfg(4'h8);
    for (int i = 0; i < 18; i++)
    begin
      m.send(8'(i), 8, 1'b0, 1'b0);
      repeat (5) @(negedge mclk);
      if (i == 16)
        chk({7'h0, ovf}, 8'h00);
    end
    chk({7'h0, rdy}, 8'h00);
    chk({7'h0, ovf}, 8'h01);
    for (int i = 0; i < 17; i++)
      get(8'(i));
    chk({7'h0, val}, 8'h00);
    @(posedge mclk) oclr <= 1'b1;
    @(posedge mclk) oclr <= 1'b0;
    @(negedge mclk);
    chk({7'h0, ovf}, 8'h00);
  endtask
  task automatic t_tx;
    @(posedge mclk) txw <= 1'b1;
    txd <= 8'h5a;
    @(posedge mclk) txd <= 8'hc3;
    @(posedge mclk) txw <= 1'b0;
    @(negedge mclk);
    chk(txb, 8'hc3);
    chk({7'h0, bff}, 8'h01);
    @(posedge mclk) txt <= 1'b1;
    @(posedge mclk) txt <= 1'b0;
    @(negedge mclk);
    chk({7'h0, bff}, 8'h00);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_formats();
    t_isel();
    t_overrun();
    t_tx();
    report_and_stop();
  end
  // The tests need about 1700 cycles; 20000 leaves room for slow paths.
  initial
  begin
    #2000000;
    fails++;
    report_and_stop();
  end
endmodule
